// *** pcmvp_port.v ***
// pcm voice port master: drives bit clock, short frame sync and data out,
// and samples data in from an external codec
// assumes pcm_din_i is asynchronous; user side is on core_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "pcmvp_regs.vh"
module pcmvp_port #(
    parameter integer CLK_HZ         = `PCMVP_CORE_CLK_HZ,
    parameter integer BIT_CLK_HZ     = `PCMVP_BIT_CLK_HZ,
    parameter integer BITS_PER_FRAME = `PCMVP_BITS_PER_FRAME
) (
    input  wire        core_clk_i,
    input  wire        reset_i,
    input  wire        enable_i,
    input  wire [1:0]  format_i,
    input  wire [15:0] tx_sample_i,
    output reg         tx_taken_o,
    output reg  [15:0] rx_sample_o,
    output reg         rx_valid_o,
    output reg         pcm_clk_o,
    output reg         pcm_sync_o,
    output reg         pcm_dout_o,
    input  wire        pcm_din_i
);
    localparam integer LAST_BIT_INT = BITS_PER_FRAME - 1;
    localparam [7:0]   LAST_BIT     = LAST_BIT_INT[7:0];

    // 8-bit companded codes travel in the low byte of the sample words
    function [4:0] slot_len;
        input [1:0] fmt;
        begin
            if (fmt == `PCMVP_FMT_ALAW || fmt == `PCMVP_FMT_MULAW)
                slot_len = `PCMVP_SLOT_LEN_8;
            else
                slot_len = `PCMVP_SLOT_LEN_16;
        end
    endfunction

    wire        half_tick;
    reg         din_meta;
    reg         din_sync;
    reg  [7:0]  bit_cnt;
    reg  [1:0]  fmt;
    reg  [15:0] tx_shift;
    reg  [15:0] rx_shift;

    wire [7:0]  next_cnt  = (bit_cnt == LAST_BIT) ? 8'h00 : bit_cnt + 8'h01;
    wire [4:0]  cur_len   = slot_len(fmt);
    wire [4:0]  new_len   = slot_len(format_i);
    wire [15:0] tx_loaded = (new_len == `PCMVP_SLOT_LEN_8) ?
                            {tx_sample_i[7:0], 8'h00} : tx_sample_i;
    wire [15:0] rx_word   = {rx_shift[14:0], din_sync};

    pcmvp_rate_gen #(
        .CLK_HZ  (CLK_HZ),
        .TICK_HZ (2 * BIT_CLK_HZ)
    ) pcmvp_rate_gen_inst (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .run_i      (enable_i),
        .tick_o     (half_tick)
    );

    always @(posedge core_clk_i) begin
        din_meta <= pcm_din_i;
        din_sync <= din_meta;
    end

    always @(posedge core_clk_i) begin
        tx_taken_o <= 1'b0;
        rx_valid_o <= 1'b0;
        if (reset_i || !enable_i) begin
            // first rising edge after enable starts bit 0 of a frame
            bit_cnt     <= LAST_BIT;
            fmt         <= `PCMVP_FMT_LINEAR;
            tx_shift    <= 16'h0000;
            rx_shift    <= 16'h0000;
            rx_sample_o <= 16'h0000;
            pcm_clk_o   <= 1'b0;
            pcm_sync_o  <= 1'b0;
            pcm_dout_o  <= 1'b0;
        end else if (half_tick) begin
            pcm_clk_o <= ~pcm_clk_o;
            if (!pcm_clk_o) begin
                // rising edge: advance the bit and launch outgoing data
                bit_cnt    <= next_cnt;
                pcm_sync_o <= (next_cnt == LAST_BIT);
                if (next_cnt == 8'h00) begin
                    fmt        <= format_i;
                    tx_shift   <= tx_loaded;
                    pcm_dout_o <= tx_loaded[15];
                    tx_taken_o <= 1'b1;
                end else begin
                    tx_shift   <= {tx_shift[14:0], 1'b0};
                    pcm_dout_o <= ({3'h0, cur_len} > next_cnt) ? tx_shift[14] : 1'b0;
                end
            end else if ({3'h0, cur_len} > bit_cnt) begin
                // falling edge: sample incoming data, msb first
                rx_shift <= rx_word;
                if (bit_cnt == {3'h0, cur_len} - 8'h01) begin
                    rx_sample_o <= (cur_len == `PCMVP_SLOT_LEN_8) ?
                                   {8'h00, rx_word[7:0]} : rx_word;
                    rx_valid_o  <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** pcmvp_regs.vh ***
// constants for the pcm voice port: rates, frame layout and format codes
// assumes a single core clock; no software-visible registers exist
//
// Overview of operation
// - each slot carries 8-bit a-law, 8-bit mu-law or 16-bit linear data
// - frame sync is generated at 8 khz, one frame start per period
// - bit clock is driven at 2048 khz, 256 bit periods per frame
// - short frame: sync lasts one bit period just before the first data bit
// - device sources sync and bit clock; the codec follows them
`ifndef PCMVP_REGS_VH
`define PCMVP_REGS_VH

`define PCMVP_CORE_CLK_HZ     20000000
`define PCMVP_BIT_CLK_HZ      2048000
`define PCMVP_SYNC_HZ         8000
`define PCMVP_BITS_PER_FRAME  (`PCMVP_BIT_CLK_HZ / `PCMVP_SYNC_HZ)
`define PCMVP_HALF_BIT_HZ     (2 * `PCMVP_BIT_CLK_HZ)

`define PCMVP_FMT_LINEAR      2'h0
`define PCMVP_FMT_ALAW        2'h1
`define PCMVP_FMT_MULAW       2'h2

`define PCMVP_SLOT_LEN_8      5'h08
`define PCMVP_SLOT_LEN_16     5'h10

`endif

// *** pcmvp_rate_gen.v ***
// fractional rate generator: one-cycle enable pulses at an average rate
// assumes core clock rate is above the requested pulse rate
`timescale 1ns/1ps
`default_nettype none
module pcmvp_rate_gen #(
    parameter integer CLK_HZ  = 20000000,
    parameter integer TICK_HZ = 4096000
) (
    input  wire        core_clk_i,
    input  wire        reset_i,
    input  wire        run_i,
    output reg         tick_o
);
    // the core clock is not an integer multiple of the bit clock, so the
    // period jitters by one core cycle while the average rate stays exact
    localparam [24:0] STEP = TICK_HZ[24:0];
    localparam [24:0] WRAP = CLK_HZ[24:0];

    reg  [24:0] acc;
    wire [24:0] next_acc = acc + STEP;

    always @(posedge core_clk_i) begin
        if (reset_i || !run_i) begin
            acc    <= 25'h0000000;
            tick_o <= 1'b0;
        end else if (next_acc >= WRAP) begin
            acc    <= next_acc - WRAP;
            tick_o <= 1'b1;
        end else begin
            acc    <= next_acc;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** pcmvp_port_asserts.sv ***
// pin checks for pcmvp_port
// assumes every output is clocked by core_clk_i
`timescale 1ns/1ps
`default_nettype none
module pcmvp_port_chk (
    input wire logic core_clk_i, reset_i, enable_i, tx_taken_o,
    input wire logic pcm_clk_o, pcm_sync_o, pcm_dout_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i || !enable_i);
    logic [11:0] gap;
    logic        armed;
    // armed skips frame 0, which has no leading sync
    always @(posedge core_clk_i) begin
        gap <= $rose(pcm_sync_o) ? 12'h000 : gap + 12'h001;
        armed <= !reset_i && enable_i && (armed || $rose(pcm_sync_o));
    end
    a_sync_width: assert property ($rose(pcm_sync_o) |-> pcm_sync_o[*8])
        else $error("sync short");
    a_sync_edge: assert property ($fell(pcm_sync_o) |-> $rose(pcm_clk_o))
        else $error("sync off edge");
    // the load pulse is registered on the same edge that drops sync
    a_taken_bit0: assert property ($fell(pcm_sync_o) |-> tx_taken_o)
        else $error("no load at bit 0");
    a_dout_rise: assert property ($changed(pcm_dout_o) |-> $rose(pcm_clk_o))
        else $error("dout off edge");
    a_clk_half: assert property ($rose(pcm_clk_o) |-> pcm_clk_o[*4] ##[1:2] !pcm_clk_o)
        else $error("bit clock high wrong");
    a_frame_len: assert property ($rose(pcm_sync_o) && armed |-> gap == 12'h9C3)
        else $error("frame length wrong");
endmodule
bind pcmvp_port pcmvp_port_chk pcmvp_port_chk_inst (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .enable_i(enable_i), .tx_taken_o(tx_taken_o),
    .pcm_clk_o(pcm_clk_o), .pcm_sync_o(pcm_sync_o), .pcm_dout_o(pcm_dout_o));
`default_nettype wire

// *** pcmvp_codec_model.sv ***
// codec follower: din msb first on clock rise, dout taken on fall
// assumes enable stays high once framing starts
`timescale 1ns/1ps
`default_nettype none
module pcmvp_codec_model (
    input  wire logic        pcm_clk_i, pcm_sync_i, pcm_dout_i, wide_i,
    input  wire logic [15:0] tx_word_i,
    output var  logic        pcm_din_o = 1'b0,
    output var  logic [15:0] rx_word_o = 16'h0000
);
    logic [7:0]  idx = 8'hFF;
    logic [15:0] sh;
    logic        last = 1'b0;
    wire  [7:0]  len = wide_i ? 8'h10 : 8'h08;
    always @(negedge pcm_clk_i) begin
        last <= pcm_sync_i;
        sh = {sh[14:0], pcm_dout_i};
        if (idx == len - 8'h01) rx_word_o <= wide_i ? sh : {8'h00, sh[7:0]};
    end
    // outside the slot din toggles so a stale bit never passes as data
    always @(posedge pcm_clk_i) begin
        idx = last ? 8'h00 : idx + 8'h01;
        pcm_din_o <= idx < len ? tx_word_i[len - 8'h01 - idx] : ~pcm_din_o;
    end
endmodule
`default_nettype wire

// *** test_pcmvp_port.sv ***
// bench for pcmvp_port against the codec model
// assumes full-length frames of 2500 core cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_pcmvp_port;
    logic        core_clk_i = 0, reset_i = 1, enable_i = 1, wide = 1, din;
    logic [1:0]  format_i = 0;
    logic [15:0] tx_sample_i = 0, tx_word = 0, rx_word, rx_sample_o;
    logic        tx_taken_o, rx_valid_o, pcm_clk_o, pcm_sync_o, pcm_dout_o;
    int          err_count = 0, tests_run = 0;
    always #25 core_clk_i = ~core_clk_i;
    pcmvp_port pcmvp_port_inst (.core_clk_i, .reset_i, .enable_i, .format_i, .tx_sample_i,
        .tx_taken_o, .rx_sample_o, .rx_valid_o, .pcm_clk_o, .pcm_sync_o, .pcm_dout_o,
        .pcm_din_i(din));
    pcmvp_codec_model pcmvp_codec_model_inst (.pcm_clk_i(pcm_clk_o), .pcm_sync_i(pcm_sync_o),
        .pcm_dout_i(pcm_dout_o), .wide_i(wide), .tx_word_i(tx_word), .pcm_din_o(din),
        .rx_word_o(rx_word));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_for(input bit rx);
        int n = 0;
        do begin @(posedge core_clk_i); n++; end
        while ((rx ? rx_valid_o : tx_taken_o) !== 1'b1 && n < 3000);
        if (n >= 3000) begin err_count++; end_sim; end
    endtask
    // codes 0..3; 3 runs as linear
    task automatic test_formats;
        logic [15:0] tv, cw;
        bit          w;
        for (int i = 0; i < 4; i++) begin
            tv = 16'hA5C3 - i[15:0];
            cw = 16'h96E1 + i[15:0];
            w = i != 1 && i != 2;
            wait_for(0);
            format_i <= i[1:0];
            tx_sample_i <= tv;
            tx_word <= cw;
            wide <= w;
            wait_for(0);
            wait_for(1);
            `CHK(rx_sample_o, w ? cw : {8'h00, cw[7:0]})
            `CHK(rx_word, w ? tv : {8'h00, tv[7:0]})
        end
        $display("test formats done");
    endtask
    task automatic test_reset;
        @(posedge core_clk_i) reset_i <= 1;
        repeat (2) @(posedge core_clk_i);
        `CHK({pcm_clk_o, pcm_sync_o, pcm_dout_o, tx_taken_o, rx_valid_o, rx_sample_o}, 21'h0)
        // frame 0 after release has no sync, so the codec is checked one frame later
        reset_i <= 0;
        wait_for(0);
        wait_for(0);
        wait_for(1);
        `CHK(rx_sample_o, tx_word)
        `CHK(rx_word, tx_sample_i)
        $display("test reset done");
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_i <= 0;
        test_formats;
        test_reset;
        end_sim;
    end
endmodule
`default_nettype wire
